// ---- verilog/mii_phy_port.sv ----
// Contract
// - management clock treated as asynchronous to nibble clocks
// - management data open drain, pulled high when idle
// - half duplex: carrier on receive or transmit
// - full duplex: carrier on receive only
// - half duplex: collision on simultaneous transmit and receive
// - 10 mb/s half duplex heartbeat: one microsecond pulse
// - full duplex: collision low, no heartbeat
// - transmit clock 25 or 2.5 mhz
// - 100 mb/s: transmit error sends halt code
// - 10 mb/s: transmit error ignored
// - receive clock 25 or 2.5 mhz
// - receive data changes on falling receive clock
// - 100 mb/s: receive error on invalid symbol
// - receive valid with data, changes on falling edge
`timescale 1ns/1ns
module mii_phy_port
  import mii_port_pkg::*;
(
  // core clock and asynchronous reset
  input  wire logic                clock_in,
  input  wire logic                arst_n_in,
  // operating mode levels
  input  wire logic                speed_100_in,
  input  wire logic                full_duplex_in,
  input  wire logic                heartbeat_en_in,
  // mii transmit side, mac to phy
  output logic                     tx_clk_out,
  input  wire logic [NIBBLE_W-1:0] txd_in,
  input  wire logic                tx_en_in,
  input  wire logic                tx_er_in,
  // mii receive side, phy to mac
  output logic                     rx_clk_out,
  output logic [NIBBLE_W-1:0]      rxd_out,
  output logic                     rx_dv_out,
  output logic                     rx_er_out,
  // mii status
  output logic                     crs_out,
  output logic                     col_out,
  // management pins, data as open drain triple
  input  wire logic                mdc_in,
  input  wire logic                mdio_in,
  output logic                     mdio_out,
  output logic                     mdio_oe_out,
  // management logic side
  input  wire logic                mgmt_drive_low_in,
  output logic                     mgmt_mdio_out,
  output logic                     mgmt_mdc_rise_out,
  // line side transmit nibbles
  output logic [NIBBLE_W-1:0]      line_tx_nibble_out,
  output logic                     line_tx_valid_out,
  output logic                     line_tx_halt_out,
  // line side receive nibbles
  input  wire logic [NIBBLE_W-1:0] line_rx_nibble_in,
  input  wire logic                line_rx_sym_err_in,
  input  wire logic                line_rx_valid_in,
  output logic                     line_rx_ready_out,
  input  wire logic                line_rx_active_in
);

  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------

  logic rst_meta_q;  // first stage of the reset release
  logic rst_n_q;     // reset copy used by the whole block

  // assert at once, release two edges later so no flop sees a runt
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // nibble clocks
  // ----------------------------------------------------------------------

  logic tx_rise_next;  // transmit clock rises at the next edge
  logic rx_fall_next;  // receive clock falls at the next edge

  // transmit clock from the core reference
  nibble_clock_div tx_div (
    .clock_in      (clock_in),
    .rst_n_in      (rst_n_q),
    .speed_100_in  (speed_100_in),
    .clk_out       (tx_clk_out),
    .rise_next_out (tx_rise_next),
    .fall_next_out ()
  );

  // receive clock; the line side paces words into the buffer, and this
  // divider stands in for the recovered clock at the nominal rate
  nibble_clock_div rx_div (
    .clock_in      (clock_in),
    .rst_n_in      (rst_n_q),
    .speed_100_in  (speed_100_in),
    .clk_out       (rx_clk_out),
    .rise_next_out (),
    .fall_next_out (rx_fall_next)
  );

  // ----------------------------------------------------------------------
  // transmit path
  // ----------------------------------------------------------------------

  logic [NIBBLE_W-1:0] tx_nibble_q;  // nibble passed to the line
  logic                tx_valid_q;   // nibble slot is live
  logic                tx_halt_q;    // halt code replaces the nibble
  logic                tx_active_q;  // transmit activity, for crs/col
  logic                tx_err_used;  // error honoured at this speed

  // the error input only counts at 100 mb/s
  assign tx_err_used = speed_100_in && tx_er_in;

  // sample the mac on the core edge that raises our own clock; the mac
  // moved its outputs after the previous rise, so they have settled
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_nibble_q <= NIBBLE_RST;
      tx_valid_q  <= 1'b0;
      tx_halt_q   <= 1'b0;
      tx_active_q <= 1'b0;
    end else if (tx_rise_next) begin
      // mac frames its nibbles with the enable alone
      tx_valid_q  <= tx_en_in;
      tx_active_q <= tx_en_in;
      if (tx_en_in && tx_err_used) begin
        // halt group goes out in place of the data
        tx_halt_q   <= 1'b1;
        tx_nibble_q <= HALT_CODE;
      end else begin
        tx_halt_q   <= 1'b0;
        tx_nibble_q <= tx_en_in ? txd_in : NIBBLE_RST;
      end
    end
  end

  assign line_tx_nibble_out = tx_nibble_q;
  assign line_tx_valid_out  = tx_valid_q;
  assign line_tx_halt_out   = tx_halt_q;

  // ----------------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------------

  localparam int unsigned RX_W = NIBBLE_W + 1;  // nibble plus error

  logic [RX_W-1:0]     rx_word;      // buffered word at the head
  logic                rx_avail;     // a word is waiting
  logic [NIBBLE_W-1:0] rxd_q;        // receive data pins
  logic                rx_dv_q;      // receive valid pin
  logic                rx_er_q;      // receive error pin

  // the buffer absorbs line words while the slow mii side drains them;
  // when it is full the line side sees ready drop and holds its word
  two_entry_buffer #(
    .WIDTH (RX_W)
  ) rx_buf (
    .clock_in      (clock_in),
    .rst_n_in      (rst_n_q),
    .in_data_in    ({line_rx_sym_err_in, line_rx_nibble_in}),
    .in_valid_in   (line_rx_valid_in),
    .in_ready_out  (line_rx_ready_out),
    .out_data_out  (rx_word),
    .out_valid_out (rx_avail),
    .out_ready_in  (rx_fall_next)
  );

  // outputs move together with the falling receive clock, leaving half a
  // period of setup at 10 mb/s and three fifths at 100 mb/s before the mac samples on the rising edge
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rxd_q   <= NIBBLE_RST;
      rx_dv_q <= 1'b0;
      rx_er_q <= 1'b0;
    end else if (rx_fall_next) begin
      if (rx_avail) begin
        // a word is handed out on this very edge
        rxd_q   <= rx_word[NIBBLE_W-1:0];
        rx_dv_q <= 1'b1;
        // symbol errors are reported only at 100 mb/s
        rx_er_q <= speed_100_in && rx_word[NIBBLE_W];
      end else begin
        // nothing queued: idle the pins
        rxd_q   <= NIBBLE_RST;
        rx_dv_q <= 1'b0;
        rx_er_q <= 1'b0;
      end
    end
  end

  assign rxd_out   = rxd_q;
  assign rx_dv_out = rx_dv_q;
  assign rx_er_out = rx_er_q;

  // ----------------------------------------------------------------------
  // carrier sense and collision
  // ----------------------------------------------------------------------

  logic                 tx_active_d1_q;  // last transmit activity
  logic                 tx_end;          // transmit just finished
  logic [SQE_CNT_W-1:0] sqe_cnt_q;       // heartbeat cycles left
  logic                 sqe_busy;        // heartbeat pulse running
  logic                 crs_q;           // carrier sense pin
  logic                 col_q;           // collision pin

  assign tx_end   = tx_active_d1_q && !tx_active_q;
  assign sqe_busy = (sqe_cnt_q != '0);

  // remember transmit activity to find its end
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_active_d1_q <= 1'b0;
    end else begin
      tx_active_d1_q <= tx_active_q;
    end
  end

  // heartbeat timer, armed at the end of each 10 mb/s half duplex frame
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sqe_cnt_q <= '0;
    end else if (full_duplex_in || speed_100_in) begin
      // no heartbeat outside 10 mb/s half duplex
      sqe_cnt_q <= '0;
    end else if (tx_end && heartbeat_en_in) begin
      sqe_cnt_q <= SQE_CNT_W'(SQE_CYCLES);
    end else if (sqe_busy) begin
      sqe_cnt_q <= sqe_cnt_q - SQE_CNT_W'(1);
    end
  end

  // carrier: own transmissions count only in half duplex
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      crs_q <= 1'b0;
    end else if (full_duplex_in) begin
      crs_q <= line_rx_active_in;
    end else begin
      crs_q <= line_rx_active_in || tx_active_q;
    end
  end

  // collision: overlap of both directions, or the heartbeat pulse
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      col_q <= 1'b0;
    end else if (full_duplex_in) begin
      col_q <= 1'b0;
    end else begin
      col_q <= (line_rx_active_in && tx_active_q)
               || sqe_busy;
    end
  end

  assign crs_out = crs_q;
  assign col_out = col_q;

  // ----------------------------------------------------------------------
  // management pins
  // ----------------------------------------------------------------------

  logic mdc_meta_q;   // first synchroniser stage, management clock
  logic mdc_sync_q;   // synchronised management clock
  logic mdc_last_q;   // previous synchronised level
  logic mdio_meta_q;  // first synchroniser stage, management data
  logic mdio_sync_q;  // synchronised management data
  logic mdio_oe_q;    // pulling the data line low

  // both pins are treated as foreign to every nibble clock; an edge
  // detector on the core clock works for any rate down to standstill,
  // and 125 mhz sees every level of a management clock up to 25 mhz
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mdc_meta_q  <= 1'b0;
      mdc_sync_q  <= 1'b0;
      mdc_last_q  <= 1'b0;
      mdio_meta_q <= 1'b1;
      mdio_sync_q <= 1'b1;
    end else begin
      mdc_meta_q  <= mdc_in;
      mdc_sync_q  <= mdc_meta_q;
      mdc_last_q  <= mdc_sync_q;
      mdio_meta_q <= mdio_in;
      mdio_sync_q <= mdio_meta_q;
    end
  end

  assign mgmt_mdc_rise_out = mdc_sync_q && !mdc_last_q;
  assign mgmt_mdio_out     = mdio_sync_q;

  // open drain: only ever drive low, the pull-up makes the high level
  always_ff @(posedge clock_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mdio_oe_q <= 1'b0;
    end else begin
      mdio_oe_q <= mgmt_drive_low_in;
    end
  end

  assign mdio_out    = 1'b0;
  assign mdio_oe_out = mdio_oe_q;

endmodule

// ---- verilog/mii_port_pkg.sv ----
// ----------------------------------------------------------------------
// shared constants of the mac facing port
// ----------------------------------------------------------------------
package mii_port_pkg;

  // ----------------------------------------------------------------------
  // clock rates
  // ----------------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ  = 125_000_000; // core clock
  localparam int unsigned FAST_CLK_HZ = 25_000_000;  // 100 mb/s nibble
  localparam int unsigned SLOW_CLK_HZ = 2_500_000;   // 10 mb/s nibble
  localparam int unsigned MDC_MAX_HZ  = 25_000_000;  // fastest mgmt clock

  // core cycles per nibble clock period, for each speed
  localparam int unsigned FAST_DIV = SYS_CLK_HZ / FAST_CLK_HZ;
  localparam int unsigned SLOW_DIV = SYS_CLK_HZ / SLOW_CLK_HZ;

  // ----------------------------------------------------------------------
  // heartbeat (signal quality test) pulse length
  // ----------------------------------------------------------------------
  localparam int unsigned SQE_TIME_NS = 1000; // about one microsecond
  localparam int unsigned SQE_CYCLES  =
    (SQE_TIME_NS * (SYS_CLK_HZ / 1_000_000)) / 1000;

  // ----------------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned NIBBLE_W   = 4;       // mii data width
  localparam int unsigned DIV_CNT_W  = 6;       // holds SLOW_DIV - 1
  localparam int unsigned SQE_CNT_W  = 8;       // holds SQE_CYCLES
  localparam logic [3:0]  NIBBLE_RST = 4'h0;    // data after reset
  localparam logic [3:0]  HALT_CODE  = 4'h4;    // tag on halt nibbles

endpackage

// ---- verilog/nibble_clock_div.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// nibble clock divider: drives a pin clock and strobes one core cycle
// before each of its edges, so data can move with the edge itself
// ----------------------------------------------------------------------
module nibble_clock_div
  import mii_port_pkg::*;
(
  // core clock and reset
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  // speed select: high for 25 mhz, low for 2.5 mhz
  input  wire logic speed_100_in,
  // pin clock and edge strobes
  output logic      clk_out,
  output logic      rise_next_out,
  output logic      fall_next_out
);

  logic [DIV_CNT_W-1:0] cnt_q;   // position inside one period
  logic [DIV_CNT_W-1:0] cnt_d;   // next position
  logic [DIV_CNT_W-1:0] last;    // final count of the period
  logic [DIV_CNT_W-1:0] half;    // counts spent high
  logic                 clk_q;   // pin clock level

  // period shape follows the selected speed
  always_comb begin
    last = speed_100_in ? DIV_CNT_W'(FAST_DIV - 1) : DIV_CNT_W'(SLOW_DIV - 1);
    half = speed_100_in ? DIV_CNT_W'(FAST_DIV / 2) : DIV_CNT_W'(SLOW_DIV / 2);
    // a change to 100 mb/s mid period just wraps early, no runt high phase
    cnt_d = (cnt_q >= last) ? '0 : cnt_q + DIV_CNT_W'(1);
  end

  // strobes: the next edge moves the pin clock
  assign rise_next_out = (cnt_q >= last);
  assign fall_next_out = (cnt_q == half - DIV_CNT_W'(1));
  assign clk_out       = clk_q;

  // counter and pin clock, high for the first half of each period at 10 mb/s, two of five counts at 100 mb/s
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
      clk_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      clk_q <= (cnt_d < half);
    end
  end

endmodule

// ---- verilog/two_entry_buffer.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// two entry buffer with valid and ready on both sides
// ----------------------------------------------------------------------
module two_entry_buffer #(
  parameter int unsigned WIDTH = 5  // word width
) (
  // core clock and reset
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  // filling side
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  // draining side
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);

  logic [WIDTH-1:0] head_q;   // oldest word
  logic [WIDTH-1:0] tail_q;   // second word
  logic [1:0]       count_q;  // words held
  logic             push;     // word taken in
  logic             pop;      // word handed out

  assign in_ready_out  = (count_q != 2'h2);
  assign out_valid_out = (count_q != 2'h0);
  assign out_data_out  = head_q;
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_ready_in && out_valid_out;

  // occupancy
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_q <= 2'h0;
    end else if (push && !pop) begin
      count_q <= count_q + 2'h1;
    end else if (pop && !push) begin
      count_q <= count_q - 2'h1;
    end
  end

  // storage: the head refills from the tail or from the input
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      head_q <= '0;
      tail_q <= '0;
    end else begin
      if (pop) begin
        head_q <= (count_q == 2'h2) ? tail_q : in_data_in;
      end else if (push && count_q == 2'h0) begin
        head_q <= in_data_in;
      end
      if (push && (count_q == 2'h2 || (count_q == 2'h1 && !pop))) begin
        tail_q <= in_data_in;
      end
    end
  end

endmodule

// ---- bench/mii_phy_port_asserts.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module mii_phy_port_asserts
  import mii_port_pkg::*;
(
  // clock, reset and modes
  input wire logic clock_in, arst_n_in, speed_100_in, full_duplex_in,
  // transmit side
  input wire logic tx_clk_out, tx_en_in, tx_er_in, line_tx_valid_out,
  input wire logic line_tx_halt_out,
  // receive side and status
  input wire logic rx_clk_out, rx_dv_out, rx_er_out, line_rx_active_in,
  input wire logic [NIBBLE_W-1:0] rxd_out,
  input wire logic crs_out, col_out,
  // management pins
  input wire logic mdio_out, mdio_oe_out, mgmt_drive_low_in
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);

  // one 25 mhz period: two core cycles high, three low
  sequence fast_period;
    tx_clk_out [*2] ##1 (!tx_clk_out) [*3] ##1 tx_clk_out;
  endsequence
  // leaving 100 mb/s may stretch the divider period
  sequence speed_left;
    ##[1:5] !speed_100_in;
  endsequence

  a_tx_clk_shape: assert property (
    $rose(tx_clk_out) && speed_100_in |-> fast_period or speed_left)
    else $error("transmit clock shape wrong at 100 mb/s");
  a_half_carrier: assert property (
    !full_duplex_in && line_rx_active_in |=> crs_out)
    else $error("carrier low during half duplex receive");
  a_full_carrier: assert property (
    full_duplex_in |=> crs_out == $past(line_rx_active_in))
    else $error("full duplex carrier not tied to receive");
  a_half_collision: assert property (
    !full_duplex_in && line_rx_active_in && line_tx_valid_out |=> col_out)
    else $error("collision missing");
  a_full_no_col: assert property (
    full_duplex_in |=> !col_out)
    else $error("collision in full duplex");
  a_halt_code: assert property (
    $rose(tx_clk_out) |->
      line_tx_halt_out == $past(tx_en_in && tx_er_in && speed_100_in))
    else $error("halt flag wrong");
  a_rxd_on_fall: assert property (
    $changed(rxd_out) |-> $fell(rx_clk_out))
    else $error("receive data moved off the falling edge");
  a_dv_on_fall: assert property (
    $changed(rx_dv_out) |-> $fell(rx_clk_out))
    else $error("receive valid moved off the falling edge");
  a_rx_er_slow: assert property (
    !speed_100_in && !$past(speed_100_in) |-> !rx_er_out)
    else $error("receive error at 10 mb/s");
  a_mdio_drain: assert property (
    mdio_oe_out == $past(mgmt_drive_low_in) && !mdio_out)
    else $error("management data not open drain");
endmodule

// ---- bench/mac_model.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------
// mac and management station model
// ----------------------------------------------------------------
module mac_model
  import mii_port_pkg::*;
(
  // receive pins from the port
  input wire logic rx_clk_in, rx_dv_in, rx_er_in,
  input wire logic [NIBBLE_W-1:0] rxd_in,
  // transmit pins to the port
  output logic [NIBBLE_W-1:0] txd_out,
  output logic tx_en_out, tx_er_out,
  // management clock and open drain pull
  output logic mdc_out, mdio_low_out
);
  logic [4:0] rx_q [$]; // captured error and nibble

  initial begin
    txd_out = 4'h0;
    tx_en_out = 1'b0;
    tx_er_out = 1'b0;
    mdc_out = 1'b0;
    mdio_low_out = 1'b0;
  end

  // called just after a transmit clock rise; idle data flips so a
  // stale nibble can never pass for a held one
  task automatic drive(input logic en, er, input logic [3:0] d);
    tx_en_out = en;
    tx_er_out = er;
    txd_out = en ? d : ~txd_out;
  endtask

  // sample half a period after the port moves the data, three fifths at 100 mb/s
  always @(posedge rx_clk_in) begin
    if (rx_dv_in === 1'b1)
      rx_q.push_back({rx_er_in, rxd_in});
  end

  // 40 ns period, the fastest allowed; rests low between bursts
  task automatic mdc_burst(input int n);
    repeat (n) begin
      #20 mdc_out = 1'b1;
      #20 mdc_out = 1'b0;
    end
  endtask

  // pull the shared data line low or let it go
  task automatic pull_low(input logic v);
    mdio_low_out = v;
  endtask
endmodule

// ---- bench/tb_mii_phy_port.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------
// bench for the mac facing port
// ----------------------------------------------------------------
module tb_mii_phy_port;
  import mii_port_pkg::*;
  logic clock_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic speed_100_in = 1'b1;
  logic full_duplex_in = 1'b0;
  logic heartbeat_en_in = 1'b1;
  logic mgmt_drive_low_in = 1'b0;
  logic line_rx_valid_in = 1'b0;
  logic line_rx_sym_err_in = 1'b0;
  logic line_rx_active_in = 1'b0;
  logic [NIBBLE_W-1:0] line_rx_nibble_in = 4'h0;
  logic [NIBBLE_W-1:0] txd_in, rxd_out, line_tx_nibble_out;
  logic tx_en_in, tx_er_in, mdc_in, mdio_in, mdio_low;
  logic tx_clk_out, rx_clk_out, rx_dv_out, rx_er_out, crs_out, col_out;
  logic mdio_out, mdio_oe_out, mgmt_mdio_out, mgmt_mdc_rise_out;
  logic line_tx_valid_out, line_tx_halt_out, line_rx_ready_out;
  int num_errors = 0;
  int checks = 0;
  int rise_cnt = 0; // synchronised mdc rises seen

  always #4 clock_in = ~clock_in;
  // open drain line with pull-up: low while anyone pulls
  assign mdio_in = (mdio_oe_out | mdio_low) ? 1'b0 : 1'b1;
  always @(posedge clock_in) begin
    if (mgmt_mdc_rise_out === 1'b1)
      rise_cnt <= rise_cnt + 1;
  end

  mii_phy_port u_mii_phy_port (
    .clock_in, .arst_n_in, .speed_100_in, .full_duplex_in, .heartbeat_en_in,
    .tx_clk_out, .txd_in, .tx_en_in, .tx_er_in, .rx_clk_out, .rxd_out,
    .rx_dv_out, .rx_er_out, .crs_out, .col_out, .mdc_in, .mdio_in,
    .mdio_out, .mdio_oe_out, .mgmt_drive_low_in, .mgmt_mdio_out,
    .mgmt_mdc_rise_out, .line_tx_nibble_out, .line_tx_valid_out,
    .line_tx_halt_out, .line_rx_nibble_in, .line_rx_sym_err_in,
    .line_rx_valid_in, .line_rx_ready_out, .line_rx_active_in
  );
  mac_model u_mac_model (
    .rx_clk_in(rx_clk_out), .rx_dv_in(rx_dv_out), .rx_er_in(rx_er_out),
    .rxd_in(rxd_out), .txd_out(txd_in), .tx_en_out(tx_en_in),
    .tx_er_out(tx_er_in), .mdc_out(mdc_in), .mdio_low_out(mdio_low)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  // bounded wait for a nibble clock rise; n gives cycles waited
  task automatic wait_rise(input bit sel, output int n);
    logic p;
    p = 1'b1;
    for (n = 1; n <= 120; n++) begin
      cyc(1);
      if ((sel ? rx_clk_out : tx_clk_out) === 1'b1 && !p)
        return;
      p = sel ? rx_clk_out : tx_clk_out;
    end
    num_errors++;
    results();
  endtask
  // one nibble, entered just after a transmit clock rise
  task automatic tx_step(input logic en, er, input logic [3:0] d);
    logic h;
    int n;
    h = en & er & speed_100_in;
    u_mac_model.drive(en, er, d);
    wait_rise(0, n);
    chk("tx valid", en, line_tx_valid_out);
    chk("tx halt", h, line_tx_halt_out);
    chk("tx nibble", en ? (h ? HALT_CODE : d) : 4'h0, line_tx_nibble_out);
  endtask
  // offer a word; valid stays up for the next one; ready is read
  // where it has settled, so the edge after it takes the word
  task automatic push(input logic [4:0] w);
    int i;
    line_rx_nibble_in = w[3:0];
    line_rx_sym_err_in = w[4];
    line_rx_valid_in = 1'b1;
    for (i = 0; i < 200 && line_rx_ready_out !== 1'b1; i++)
      cyc(1);
    if (i == 200) begin
      num_errors++;
      results();
    end
    cyc(1);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_clocks;
    int n;
    for (int s = 0; s < 2; s++) begin
      speed_100_in = (s == 1);
      for (int k = 0; k < 2; k++) begin
        wait_rise(k[0], n);
        wait_rise(k[0], n);
        chk("clock period", s ? FAST_DIV : SLOW_DIV, n);
      end
    end
    $display("clock test done");
  endtask
  task automatic t_tx;
    int n;
    for (int s = 1; s >= 0; s--) begin
      speed_100_in = (s == 1);
      wait_rise(0, n);
      tx_step(1'b1, 1'b0, 4'h0);
      tx_step(1'b1, 1'b1, 4'h5);
      tx_step(1'b1, 1'b0, 4'hF);
      tx_step(1'b0, 1'b1, 4'h3);
      tx_step(1'b0, 1'b0, 4'h0);
    end
    $display("transmit test done");
  endtask
  // four words into the two entry buffer, so the source stalls
  task automatic t_rx;
    logic [4:0] w [4];
    w = '{5'h01, 5'h12, 5'h0E, 5'h1F};
    for (int s = 1; s >= 0; s--) begin
      speed_100_in = (s == 1);
      cyc(2);
      foreach (w[k]) push(w[k]);
      line_rx_valid_in = 1'b0;
      line_rx_nibble_in = ~line_rx_nibble_in;
      for (int i = 0; i < 400 && u_mac_model.rx_q.size() < 4; i++) cyc(1);
      chk("rx count", 4, u_mac_model.rx_q.size());
      foreach (w[k]) chk("rx word", {w[k][4] & s[0], w[k][3:0]}, u_mac_model.rx_q[k]);
      u_mac_model.rx_q.delete();
      cyc(60);
    end
    $display("receive test done");
  endtask
  // every mix of duplex, receive and transmit activity at 100 mb/s
  task automatic t_status;
    int n;
    speed_100_in = 1'b1;
    wait_rise(0, n);
    for (int i = 0; i < 8; i++) begin
      full_duplex_in = i[2];
      line_rx_active_in = i[1];
      tx_step(i[0], 1'b0, 4'h6);
      cyc(1);
      chk("carrier", i[1] | (i[0] & !i[2]), crs_out);
      chk("collision", i[1] & i[0] & !i[2], col_out);
    end
    tx_step(1'b0, 1'b0, 4'h0);
    full_duplex_in = 1'b0;
    line_rx_active_in = 1'b0;
    $display("status test done");
  endtask
  // half with heartbeat, full, half without heartbeat
  task automatic t_heartbeat;
    int n, cnt;
    speed_100_in = 1'b0;
    for (int k = 0; k < 3; k++) begin
      full_duplex_in = (k == 1);
      heartbeat_en_in = (k != 2);
      wait_rise(0, n);
      tx_step(1'b1, 1'b0, 4'h9);
      tx_step(1'b0, 1'b0, 4'h0);
      cnt = 0;
      for (int i = 0; i < 250; i++) begin
        cyc(1);
        if (col_out === 1'b1)
          cnt++;
      end
      chk("heartbeat", k == 0 ? SQE_CYCLES : 0, cnt);
    end
    $display("heartbeat test done");
  endtask
  task automatic t_mgmt;
    int base;
    mgmt_drive_low_in = 1'b1;
    cyc(4);
    chk("mdio wire", 0, mdio_in);
    chk("mgmt mdio", 0, mgmt_mdio_out);
    mgmt_drive_low_in = 1'b0;
    u_mac_model.pull_low(1'b1);
    cyc(4);
    chk("mdio oe", 0, mdio_oe_out);
    chk("mgmt mdio", 0, mgmt_mdio_out);
    u_mac_model.pull_low(1'b0);
    cyc(4);
    chk("mgmt mdio", 1, mgmt_mdio_out);
    base = rise_cnt;
    u_mac_model.mdc_burst(8);
    cyc(4);
    chk("mdc rises", 8, rise_cnt - base);
    $display("management test done");
  endtask

  initial begin
    cyc(16);
    arst_n_in = 1'b1;
    cyc(4);
    t_clocks();
    t_tx();
    t_rx();
    t_status();
    t_heartbeat();
    t_mgmt();
    results();
  end
endmodule

bind mii_phy_port mii_phy_port_asserts u_mii_phy_port_asserts (
  .clock_in, .arst_n_in, .speed_100_in, .full_duplex_in, .tx_clk_out,
  .tx_en_in, .tx_er_in, .line_tx_valid_out, .line_tx_halt_out, .rx_clk_out,
  .rx_dv_out, .rx_er_out, .line_rx_active_in, .rxd_out, .crs_out, .col_out,
  .mdio_out, .mdio_oe_out, .mgmt_drive_low_in
);
